// [rtl/smc_standby_ctrl.sv]
/*
 * standby mode controller: reset, normal, idle, full stop and
 * stop-with-crystal sequencing, oscillator and clock gating, and the
 * watchdog and oscillator control registers on axi4-lite.
 * assumes mode instructions and accepted-interrupt strobes are one-cycle
 * pulses on sys_clk, and wake request lines are already enable-masked.
 */
// Summary of operation
// [RULE_01] reset pin or watchdog request holds reset state; release goes to normal
// [RULE_02] reset state reloads registers and stops cpu, oscillators and peripherals
// [RULE_03] memory undefined after pin reset, kept after watchdog reset and standby
// [RULE_04] idle instruction stops cpu only; accepted interrupt or reset returns
// [RULE_05] stop entry clears watchdog bit 0 when watchdog bit 3 is set
// [RULE_06] full stop loads both oscillator controls with 00 and stops everything
// [RULE_07] full stop wakes on external, port0, serial 2, sync serial 0/1 or reset
// [RULE_08] crystal stop keeps main crystal clients; crystal modules also wake
// [RULE_09] interrupt exit from stops goes idle; reset exit goes to reset
// [RULE_10] pending wake at stop entry: normal if accepting, else idle
// [RULE_11] crystal stop release restores secondary, rc and clock selection
// [RULE_12] one encoded mode state gates cpu, oscillator and peripheral clocks
`timescale 1ns/1ns
`default_nettype none
module smc_standby_ctrl
    import smc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic external_reset_pin_n,
    input wire logic watchdog_reset_req,
    input wire logic idle_instr,
    input wire logic full_stop_instr,
    input wire logic stop_keep_crystal_instr,
    input wire logic irq_accept_enable,
    input wire logic irq_accepted,
    input wire logic [7:0] external_irq,
    input wire logic port0_change_irq,
    input wire logic serial_channel_2,
    input wire logic sync_serial_0,
    input wire logic sync_serial_1,
    input wire logic crystal_module_irq,
    output logic cpu_reset,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic crystal_periph_clk_en,
    output logic main_crystal_osc_en,
    output logic secondary_osc_en,
    output logic rc_osc_en,
    output logic [1:0] sys_clk_sel,
    output logic [7:0] osc_control_1,
    output logic ram_retained,
    output logic [2:0] mode_code
);
    // ------------------------------------------------------------
    // reset sources
    // ------------------------------------------------------------
    logic pin_level_n;
    smc_sync3 #(.RESET_LEVEL(1'b1)) u_pin_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin(external_reset_pin_n),
        .level(pin_level_n)
    );
    wire pin_reset = ~pin_level_n;
    wire reset_cond = pin_reset | watchdog_reset_req; // RULE_01

    // ------------------------------------------------------------
    // mode state
    // ------------------------------------------------------------
    smc_mode_t mode;
    smc_mode_t next_mode;
    logic [7:0] watchdog_control_reg;
    logic [7:0] osc_control_0;
    logic [7:0] osc_ctrl1;

    wire in_normal = (mode == SMC_MODE_NORMAL);
    wire wake_full = (|external_irq) | port0_change_irq | serial_channel_2
        | sync_serial_0 | sync_serial_1; // RULE_07
    wire wake_xtal = wake_full | crystal_module_irq; // RULE_08
    wire go_full = in_normal & full_stop_instr;
    wire go_xtal = in_normal & stop_keep_crystal_instr & ~full_stop_instr;
    wire stop_entry = go_full | go_xtal;
    // a pending wake ends the stop before it starts
    wire pending_wake = (go_full & wake_full) | (go_xtal & wake_xtal); // RULE_10
    wire resume_mode_normal = irq_accept_enable;

    always_comb begin
        next_mode = mode;
        case (mode)
            SMC_MODE_RESET: begin
                next_mode = SMC_MODE_NORMAL; // RULE_01
            end
            SMC_MODE_NORMAL: begin
                if (pending_wake) begin
                    next_mode = resume_mode_normal ? SMC_MODE_NORMAL
                        : SMC_MODE_IDLE; // RULE_10
                end else if (go_full) begin
                    next_mode = SMC_MODE_FULL_STOP; // RULE_06
                end else if (go_xtal) begin
                    next_mode = SMC_MODE_XTAL_STOP; // RULE_08
                end else if (idle_instr) begin
                    next_mode = SMC_MODE_IDLE; // RULE_04
                end
            end
            SMC_MODE_IDLE: begin
                if (irq_accepted) begin
                    next_mode = SMC_MODE_NORMAL; // RULE_04
                end
            end
            SMC_MODE_FULL_STOP: begin
                if (wake_full) begin
                    next_mode = SMC_MODE_IDLE; // RULE_09
                end
            end
            SMC_MODE_XTAL_STOP: begin
                if (wake_xtal) begin
                    next_mode = SMC_MODE_IDLE; // RULE_09
                end
            end
            default: begin
                next_mode = SMC_MODE_RESET;
            end
        endcase
        // reset outranks every other exit
        if (reset_cond) begin
            next_mode = SMC_MODE_RESET; // RULE_01 RULE_09
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mode <= SMC_MODE_RESET;
        end else begin
            mode <= next_mode; // RULE_12
        end
    end

    // ram is only trustworthy when the last reset came from the watchdog
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ram_retained <= 1'b0;
        end else if (pin_reset) begin
            ram_retained <= 1'b0; // RULE_03
        end else if (watchdog_reset_req) begin
            ram_retained <= 1'b1; // RULE_03
        end
    end

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;

    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;
    wire do_write = aw_held & w_held & ~s_axi_bvalid;
    wire [7:0] wr_off = 8'(aw_addr);
    wire wr_wdt = do_write & w_lane0 & (wr_off == SMC_OFF_WDT_CTRL);
    wire wr_main_crystal_osc = do_write & w_lane0 & (wr_off == SMC_OFF_OSC_CTRL0);
    wire wr_secondary_osc = do_write & w_lane0 & (wr_off == SMC_OFF_OSC_CTRL1);
    wire wr_hit = (wr_off == SMC_OFF_WDT_CTRL) | (wr_off == SMC_OFF_OSC_CTRL0)
        | (wr_off == SMC_OFF_OSC_CTRL1) | (wr_off == SMC_OFF_STATUS);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SMC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held <= 1'b1;
                w_byte <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? SMC_RESP_OKAY : SMC_RESP_SLVERR;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // control registers; hardware effects outrank software writes
    // ------------------------------------------------------------
    wire in_reset = (mode == SMC_MODE_RESET);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            watchdog_control_reg <= SMC_RST_WDT_CTRL;
            osc_control_0 <= SMC_RST_OSC_CTRL0;
            osc_ctrl1 <= SMC_RST_OSC_CTRL1;
        end else if (in_reset) begin
            watchdog_control_reg <= SMC_RST_WDT_CTRL; // RULE_02
            osc_control_0 <= SMC_RST_OSC_CTRL0; // RULE_02
            osc_ctrl1 <= SMC_RST_OSC_CTRL1; // RULE_02
        end else begin
            if (stop_entry & ~pending_wake) begin
                if (watchdog_control_reg[SMC_WDT_STOP_CLR_BIT]) begin
                    watchdog_control_reg[SMC_WDT_RUN_BIT] <= 1'b0; // RULE_05
                end
            end else if (wr_wdt) begin
                watchdog_control_reg <= w_byte;
            end
            // crystal stop leaves these alone, so release restores them
            if (go_full & ~pending_wake) begin // RULE_11
                osc_control_0 <= SMC_STOP_OSC_VAL; // RULE_06
                osc_ctrl1 <= SMC_STOP_OSC_VAL; // RULE_06
            end else begin
                if (wr_main_crystal_osc) begin
                    osc_control_0 <= w_byte;
                end
                if (wr_secondary_osc) begin
                    osc_ctrl1 <= w_byte;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    wire [7:0] rd_off = 8'(s_axi_araddr);
    wire [7:0] status_byte = {4'h0, ram_retained, 3'(mode)};
    wire rd_hit = (rd_off == SMC_OFF_WDT_CTRL) | (rd_off == SMC_OFF_OSC_CTRL0)
        | (rd_off == SMC_OFF_OSC_CTRL1) | (rd_off == SMC_OFF_STATUS);
    wire [7:0] rd_byte = (rd_off == SMC_OFF_WDT_CTRL) ? watchdog_control_reg
        : (rd_off == SMC_OFF_OSC_CTRL0) ? osc_control_0
        : (rd_off == SMC_OFF_OSC_CTRL1) ? osc_ctrl1
        : (rd_off == SMC_OFF_STATUS) ? status_byte : 8'h00;
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= SMC_RESP_OKAY;
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= rd_hit ? SMC_RESP_OKAY : SMC_RESP_SLVERR;
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // clock and oscillator gating from the mode state
    // ------------------------------------------------------------
    wire mode_running = in_normal | (mode == SMC_MODE_IDLE);
    wire mode_xtal = (mode == SMC_MODE_XTAL_STOP);

    assign cpu_reset = in_reset; // RULE_02
    assign cpu_clk_en = in_normal; // RULE_04 RULE_12
    assign periph_clk_en = mode_running; // RULE_06 RULE_12
    assign crystal_periph_clk_en = mode_running | mode_xtal; // RULE_08
    assign main_crystal_osc_en = osc_control_0[SMC_MAIN_CRYSTAL_OSC_MAIN_EN_BIT]
        & (mode_running | mode_xtal); // RULE_08 RULE_12
    // rc enable is active low in the register, so gate it explicitly
    assign secondary_osc_en = osc_control_0[SMC_MAIN_CRYSTAL_OSC_SEC_EN_BIT] & mode_running; // RULE_08
    assign rc_osc_en = ~osc_control_0[SMC_MAIN_CRYSTAL_OSC_RC_STOP_BIT] & mode_running; // RULE_06
    assign sys_clk_sel = osc_control_0[SMC_MAIN_CRYSTAL_OSC_CLK_SEL_LSB+1:SMC_MAIN_CRYSTAL_OSC_CLK_SEL_LSB];
    assign osc_control_1 = osc_ctrl1;
    assign mode_code = 3'(mode);
endmodule // smc_standby_ctrl
`default_nettype wire

// [rtl/smc_pkg.sv]
/*
 * constants shared by the standby mode controller: register offsets,
 * field positions, reset values and the mode enumeration.
 * assumes a 32-bit axi4-lite register bus with byte addresses.
 */
package smc_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SMC_OFF_WDT_CTRL = 8'h00;
    localparam logic [7:0] SMC_OFF_OSC_CTRL0 = 8'h04;
    localparam logic [7:0] SMC_OFF_OSC_CTRL1 = 8'h08;
    localparam logic [7:0] SMC_OFF_STATUS = 8'h0C;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SMC_RST_WDT_CTRL = 8'h00;
    localparam logic [7:0] SMC_RST_OSC_CTRL0 = 8'h00;
    localparam logic [7:0] SMC_RST_OSC_CTRL1 = 8'h00;
    // value loaded into both oscillator controls on full stop entry
    localparam logic [7:0] SMC_STOP_OSC_VAL = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SMC_WDT_RUN_BIT = 0;
    localparam int SMC_WDT_STOP_CLR_BIT = 3;
    localparam int SMC_MAIN_CRYSTAL_OSC_MAIN_EN_BIT = 0;
    localparam int SMC_MAIN_CRYSTAL_OSC_SEC_EN_BIT = 1;
    localparam int SMC_MAIN_CRYSTAL_OSC_RC_STOP_BIT = 4;
    localparam int SMC_MAIN_CRYSTAL_OSC_CLK_SEL_LSB = 5;
    localparam int SMC_STAT_RAM_KEPT_BIT = 3;

    // ------------------------------------------------------------
    // axi responses
    // ------------------------------------------------------------
    localparam logic [1:0] SMC_RESP_OKAY = 2'h0;
    localparam logic [1:0] SMC_RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // power modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SMC_MODE_RESET,
        SMC_MODE_NORMAL,
        SMC_MODE_IDLE,
        SMC_MODE_FULL_STOP,
        SMC_MODE_XTAL_STOP
    } smc_mode_t;
endpackage

// [rtl/smc_sync3.sv]
/*
 * three flip-flop synchroniser for one pin level.
 * assumes the pin is asynchronous to sys_clk; the output moves only
 * once the second and third stages agree.
 */
`timescale 1ns/1ns
`default_nettype none
module smc_sync3 #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic pin,
    output logic level
);
    logic stage1;
    logic stage2;
    logic stage3;
    wire agree = (stage2 == stage3);

    // ------------------------------------------------------------
    // stage chain; stage1 feeds stage2 only
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stage1 <= RESET_LEVEL;
            stage2 <= RESET_LEVEL;
            stage3 <= RESET_LEVEL;
            level <= RESET_LEVEL;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            if (agree) begin
                level <= stage3;
            end
        end
    end
endmodule // smc_sync3
`default_nettype wire

// [testbench/smc_standby_monitor.sv]
/* checker on the mode and clock gating ports of smc_standby_ctrl.
   assumes one clock domain; bound into every instance of the controller */
`timescale 1ns/1ns
`default_nettype none
module smc_standby_monitor (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic external_reset_pin_n,
    input wire logic watchdog_reset_req,
    input wire logic idle_instr,
    input wire logic full_stop_instr,
    input wire logic stop_keep_crystal_instr,
    input wire logic irq_accept_enable,
    input wire logic [7:0] external_irq,
    input wire logic port0_change_irq,
    input wire logic serial_channel_2,
    input wire logic sync_serial_0,
    input wire logic sync_serial_1,
    input wire logic crystal_module_irq,
    input wire logic cpu_reset,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic crystal_periph_clk_en,
    input wire logic main_crystal_osc_en,
    input wire logic secondary_osc_en,
    input wire logic rc_osc_en,
    input wire logic [1:0] sys_clk_sel,
    input wire logic [7:0] osc_control_1,
    input wire logic ram_retained,
    input wire logic [2:0] mode_code
);
// ----------------
// helpers
// ----------------
// the pin goes through a synchroniser, so trust it only after seven high cycles
logic [2:0] pin_hi;
wire pin_ok = pin_hi == 3'h7;
wire quiet = pin_ok && !watchdog_reset_req;
wire wk = |external_irq || port0_change_irq || serial_channel_2 || sync_serial_0 || sync_serial_1;
always_ff @(posedge sys_clk or posedge rst)
    if (rst)
        pin_hi <= 3'h0;
    else if (!external_reset_pin_n)
        pin_hi <= 3'h0;
    else if (!pin_ok)
        pin_hi <= pin_hi + 3'h1;
default clocking cb @(posedge sys_clk);
endclocking
default disable iff (rst);
// ----------------
// assertions
// ----------------
a_wdt_reset: assert property (
    watchdog_reset_req |=> mode_code == 3'h0) else $error("watchdog reset missed");
a_reset_outs: assert property (
    mode_code == 3'h0 |-> cpu_reset && !cpu_clk_en && !periph_clk_en && !main_crystal_osc_en
    && !secondary_osc_en && !rc_osc_en) else $error("reset left something running");
a_ram_keep: assert property (
    mode_code == 3'h0 && pin_ok ##1 mode_code == 3'h1 |-> ram_retained) else $error("ram lost");
a_idle_entry: assert property (
    mode_code == 3'h1 && idle_instr && !full_stop_instr && !stop_keep_crystal_instr && quiet
    |=> mode_code == 3'h2 && !cpu_clk_en && periph_clk_en && $stable(osc_control_1)
    && $stable(sys_clk_sel)) else $error("idle entry wrong");
a_stop_load: assert property (
    mode_code == 3'h1 ##1 mode_code == 3'h3 |-> osc_control_1 == 8'h00 && sys_clk_sel == 2'h0
    && !main_crystal_osc_en && !crystal_periph_clk_en) else $error("full stop entry wrong");
a_stop_wake: assert property (
    mode_code == 3'h3 && wk && quiet |=> mode_code == 3'h2) else $error("full stop wake missed");
a_stop_hold: assert property (
    mode_code == 3'h3 && !wk && quiet |=> mode_code == 3'h3) else $error("full stop left early");
a_xtal_run: assert property (
    mode_code == 3'h4 |-> crystal_periph_clk_en && !periph_clk_en && !secondary_osc_en
    && !rc_osc_en) else $error("crystal stop gating wrong");
a_xtal_wake: assert property (
    mode_code == 3'h4 && crystal_module_irq && quiet |=> mode_code == 3'h2)
    else $error("crystal stop wake missed");
a_pend_wake: assert property (
    mode_code == 3'h1 && full_stop_instr && wk && quiet
    |=> mode_code == ($past(irq_accept_enable) ? 3'h1 : 3'h2)) else $error("pending wake wrong");
endmodule // smc_standby_monitor
bind smc_standby_ctrl smc_standby_monitor u_mon (.*);
`default_nettype wire

// [testbench/smc_wake_model.sv]
/* wake source model: the interrupt sources beside the controller.
   assumes bench commands; a released line reads low, as a level source does */
`timescale 1ns/1ns
`default_nettype none
module smc_wake_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] sel,
    input wire logic fire,
    input wire logic slow,
    output logic [7:0] external_irq,
    output logic port0_change_irq,
    output logic serial_channel_2,
    output logic sync_serial_0,
    output logic sync_serial_1,
    output logic crystal_module_irq
);
// ----------------
// line select, at once or three cycles late
// ----------------
logic [1:0] age;
wire on = fire && (!slow || age == 2'h3);
wire [12:0] lines = on ? 13'h1 << sel : 13'h0;
assign {crystal_module_irq, sync_serial_1, sync_serial_0, serial_channel_2, port0_change_irq,
    external_irq} = lines;
always_ff @(posedge sys_clk or posedge rst)
    if (rst)
        age <= 2'h0;
    else if (!fire)
        age <= 2'h0;
    else if (age != 2'h3)
        age <= age + 2'h1;
endmodule // smc_wake_model
`default_nettype wire

// [testbench/smc_standby_ctrl_tb.sv]
/* self-checking bench for smc_standby_ctrl: axi4-lite master, mode strobes,
   wake source model. assumes the monitor is bound by its own file */
`timescale 1ns/1ns
`default_nettype none
module smc_standby_ctrl_tb
    import smc_pkg::*;
;
logic sys_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, idle_instr;
logic [7:0] s_axi_awaddr, s_axi_araddr, external_irq, osc_control_1;
logic [31:0] s_axi_wdata, s_axi_rdata;
logic [3:0] s_axi_wstrb, sel;
logic [1:0] s_axi_bresp, s_axi_rresp, sys_clk_sel;
logic external_reset_pin_n, watchdog_reset_req, full_stop_instr, stop_keep_crystal_instr;
logic irq_accept_enable, irq_accepted, port0_change_irq, serial_channel_2, sync_serial_0;
logic sync_serial_1, crystal_module_irq, cpu_reset, cpu_clk_en, periph_clk_en, fire, slow;
logic crystal_periph_clk_en, main_crystal_osc_en, secondary_osc_en, rc_osc_en, ram_retained;
logic [2:0] mode_code;
int n_errors, num_checks;
smc_standby_ctrl u_dut (.*);
smc_wake_model u_wake (.*);
// ----------------
// helpers
// ----------------
task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
        n_errors++;
        $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
endtask
// each ready and the answer are taken at the rising edge on which they are sampled high
task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] d, output logic [1:0] r);
    logic dn = 1'h0;
    @(posedge sys_clk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, wd};
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {w, w, !w};
    while (!dn) begin
        @(posedge sys_clk);
        dn = w ? s_axi_bvalid : s_axi_rvalid;
        d = s_axi_rdata;
        r = w ? s_axi_bresp : s_axi_rresp;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {s_axi_awvalid & !s_axi_awready,
            s_axi_wvalid & !s_axi_wready, s_axi_arvalid & !s_axi_arready};
    end
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic [1:0] r;
    bus(1'h1, a, wd, d, r);
    chk(r, SMC_RESP_OKAY);
endtask
task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    bus(1'h0, a, 32'h0, d, r);
    chk(d, {24'h0, e});
endtask
task automatic mode_is(input logic [2:0] e);
    int n = 0;
    @(negedge sys_clk);
    while (mode_code !== e && n < 12) begin
        @(negedge sys_clk);
        n++;
    end
    chk(mode_code, e);
endtask
// k: 0 idle, 1 full stop, 2 crystal stop, 3 accepted interrupt
task automatic pulse(input int k);
    @(posedge sys_clk);
    {irq_accepted, stop_keep_crystal_instr, full_stop_instr, idle_instr} <= 4'h1 << k;
    @(posedge sys_clk);
    {irq_accepted, stop_keep_crystal_instr, full_stop_instr, idle_instr, fire} <= 5'h0;
endtask
task automatic wake(input logic [3:0] s, input logic [2:0] e);
    @(posedge sys_clk);
    {sel, fire, slow} <= {s, 1'h1, 1'($urandom)};
    repeat (4) @(posedge sys_clk);
    mode_is(e);
endtask
function automatic logic [7:0] exp_wdt(input logic [7:0] w);
    return w[3] ? (w & 8'hFE) : w;
endfunction
task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask
// ----------------
// clock, watchdog, tests
// ----------------
initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
end
initial begin
    #100000;
    n_errors++;
    wrap_up;
end
initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] v, w;
    void'($urandom(32'hA57F));
    {rst, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, watchdog_reset_req, fire, slow} = 7'h40;
    {idle_instr, full_stop_instr, stop_keep_crystal_instr, irq_accepted, irq_accept_enable} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, sel} = 52'h0;
    {s_axi_bready, s_axi_rready, external_reset_pin_n, s_axi_wstrb} = 7'h7F;
    repeat (3) @(posedge sys_clk);
    rst <= 1'h0;
    mode_is(3'h1);
    chk(ram_retained, 1'h0);
    rchk(SMC_OFF_WDT_CTRL, 8'h00);
    rchk(SMC_OFF_OSC_CTRL0, 8'h00);
    bus(1'h0, 8'h10, 32'h0, d, r);
    chk(d, 32'h0);
    chk(r, SMC_RESP_SLVERR);
    bus(1'h1, 8'h10, 32'hFF, d, r);
    chk(r, SMC_RESP_SLVERR);
    $display("reset test done");
    v = 8'($urandom);
    w = 8'($urandom);
    wr(SMC_OFF_OSC_CTRL0, {24'hA5A5A5, v});
    wr(SMC_OFF_OSC_CTRL1, {24'h5A5A5A, w});
    pulse(0);
    mode_is(3'h2);
    chk({cpu_clk_en, periph_clk_en, sys_clk_sel, osc_control_1}, {2'h1, v[6:5], w});
    chk({secondary_osc_en, rc_osc_en, main_crystal_osc_en}, {v[1], ~v[4], v[0]});
    pulse(3);
    mode_is(3'h1);
    $display("idle test done");
    for (int i = 0; i < 13; i++) begin
        w = 8'($urandom);
        wr(SMC_OFF_WDT_CTRL, {24'h0, w});
        pulse(1);
        mode_is(3'h3);
        chk({osc_control_1, sys_clk_sel, main_crystal_osc_en}, 11'h0);
        rchk(SMC_OFF_OSC_CTRL0, 8'h00);
        rchk(SMC_OFF_WDT_CTRL, exp_wdt(w));
        if (i == 12)
            wake(4'hC, 3'h3);
        wake(i == 12 ? 4'h0 : 4'(i), 3'h2);
        pulse(3);
    end
    $display("full stop test done");
    v = 8'($urandom);
    w = 8'($urandom);
    wr(SMC_OFF_OSC_CTRL0, {24'h0, v});
    wr(SMC_OFF_WDT_CTRL, {24'h0, w});
    pulse(2);
    mode_is(3'h4);
    chk({main_crystal_osc_en, secondary_osc_en, rc_osc_en, crystal_periph_clk_en}, {v[0], 3'h1});
    rchk(SMC_OFF_WDT_CTRL, exp_wdt(w));
    wake(4'hC, 3'h2);
    chk({sys_clk_sel, secondary_osc_en, rc_osc_en}, {v[6:5], v[1], ~v[4]});
    pulse(3);
    $display("crystal stop test done");
    for (int k = 0; k < 2; k++) begin
        wr(SMC_OFF_WDT_CTRL, 32'h9);
        irq_accept_enable <= 1'(k);
        wake(4'h9, 3'h1);
        pulse(1);
        mode_is(k == 1 ? 3'h1 : 3'h2);
        rchk(SMC_OFF_WDT_CTRL, 8'h09);
        pulse(3);
    end
    $display("pending wake test done");
    @(posedge sys_clk);
    watchdog_reset_req <= 1'h1;
    mode_is(3'h0);
    chk(cpu_reset, 1'h1);
    @(posedge sys_clk);
    watchdog_reset_req <= 1'h0;
    mode_is(3'h1);
    chk(ram_retained, 1'h1);
    rchk(SMC_OFF_OSC_CTRL0, 8'h00);
    @(posedge sys_clk);
    external_reset_pin_n <= 1'h0;
    mode_is(3'h0);
    @(posedge sys_clk);
    external_reset_pin_n <= 1'h1;
    mode_is(3'h1);
    chk(ram_retained, 1'h0);
    $display("reset source test done");
    wrap_up;
end
endmodule // smc_standby_ctrl_tb
`default_nettype wire
